// >>> hw/bafc_ctrl.v
// boost controller: current limit, min times, adaptive target, fault supervision, apb
// Notes on behaviour
// - current limit turns gate off for rest of cycle; next cycle restarts it
// - current limit sets no flag, no interrupt, no recovery
// - min on/off 150 ns low band; 110 ns on, 40 ns off high band
// - adaptive loop looks only at sinks enabled by string configuration
// - sinks flagged open or short are dropped from adaptive monitoring
// - periodic check raises target when any monitored sink lacks headroom
// - target steps down while all have headroom; stops at threshold touch
// - before sinks active ramp to 88 percent target; adapt only afterwards
// - high over-voltage enters recovery and sets its flag
// - under-voltage starts 110 ms timer, abandoned on recovery above threshold
// - timer expiry enters recovery and sets overcurrent flag
// - faults drive open-drain interrupt; cleared by host or enable falling
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "bafc_regs.vh"
module bafc_ctrl #(
  parameter NCH = 6,
  parameter TW = 10,
  parameter UV_CYCLES = `BAFC_UV_TIME_MS * 1000000 / `BAFC_CLK_NS,
  parameter ADAPT_CYCLES = `BAFC_ADAPT_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire enable_in,
  input wire current_limit_in,
  input wire overvolt_low_level,
  input wire overvolt_high_level,
  input wire undervolt_level,
  input wire [NCH-1:0] string_config_select,
  input wire [NCH-1:0] string_fault_in,
  input wire [NCH-1:0] led_sink_output,
  output reg gate_drive,
  output reg [TW-1:0] boost_target,
  output reg fault_recovery,
  output wire int_out,
  output wire int_oe,
  output wire boost_overvolt_low_flag,
  output wire boost_overvolt_high_flag,
  output wire boost_overcurrent_flag
);
  localparam [31:0] MIN_LF = (`BAFC_MIN_T_LF_NS + `BAFC_CLK_NS - 1) / `BAFC_CLK_NS;
  localparam [31:0] MIN_OFF_HF = (`BAFC_MIN_OFF_HF_NS + `BAFC_CLK_NS - 1) / `BAFC_CLK_NS;
  localparam [31:0] MIN_ON_HF = (`BAFC_MIN_ON_HF_NS + `BAFC_CLK_NS - 1) / `BAFC_CLK_NS;
  localparam [31:0] INIT_W = `BAFC_TARGET_MAX * `BAFC_INIT_PCT / 100;
  localparam [TW-1:0] INIT_T = INIT_W[TW-1:0];
  localparam [TW-1:0] TMAX = `BAFC_TARGET_MAX;
  localparam [31:0] UV_LAST = UV_CYCLES - 1;
  localparam [31:0] AD_LAST = ADAPT_CYCLES - 1;
  // three-stage synchronisers for pins
  reg [2:0] en_s, cl_s, ovl_s, ovh_s, uv_s;
  reg [NCH-1:0] hd_s1, hd_s2, hd_s3;
  reg en_q, cl_q, ovl_q, ovh_q, uv_q;
  reg [NCH-1:0] hd_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_s <= 3'b000;
      cl_s <= 3'b000;
      ovl_s <= 3'b000;
      ovh_s <= 3'b000;
      uv_s <= 3'b000;
      hd_s1 <= {NCH{1'b0}};
      hd_s2 <= {NCH{1'b0}};
      hd_s3 <= {NCH{1'b0}};
      en_q <= 1'b0;
      cl_q <= 1'b0;
      ovl_q <= 1'b0;
      ovh_q <= 1'b0;
      uv_q <= 1'b0;
      hd_q <= {NCH{1'b0}};
    end else begin
      en_s <= {en_s[1:0], enable_in};
      cl_s <= {cl_s[1:0], current_limit_in};
      ovl_s <= {ovl_s[1:0], overvolt_low_level};
      ovh_s <= {ovh_s[1:0], overvolt_high_level};
      uv_s <= {uv_s[1:0], undervolt_level};
      hd_s1 <= led_sink_output;
      hd_s2 <= hd_s1;
      hd_s3 <= hd_s2;
      if (en_s[1] == en_s[2]) en_q <= en_s[2];
      if (cl_s[1] == cl_s[2]) cl_q <= cl_s[2];
      if (ovl_s[1] == ovl_s[2]) ovl_q <= ovl_s[2];
      if (ovh_s[1] == ovh_s[2]) ovh_q <= ovh_s[2];
      if (uv_s[1] == uv_s[2]) uv_q <= uv_s[2];
      hd_q <= (hd_q & ~(hd_s2 ^ hd_s3)) | (hd_s3 & ~(hd_s2 ^ hd_s3));
    end
  end
  // apb registers
  reg [2:0] ctrl_r;
  reg [2:0] status_r;
  reg [2:0] mask_r;
  reg [15:0] period_r;
  wire wr = psel & penable & pwrite;
  wire rd = psel & penable & ~pwrite;
  reg en_d_r;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  always @* begin
    case (paddr)
      `BAFC_ADDR_CTRL: prdata = {29'h0000_0000, ctrl_r};
      `BAFC_ADDR_STATUS: prdata = {29'h0000_0000, status_r};
      `BAFC_ADDR_MASK: prdata = {29'h0000_0000, mask_r};
      `BAFC_ADDR_TARGET: prdata = {{(32-TW){1'b0}}, boost_target};
      `BAFC_ADDR_PERIOD: prdata = {16'h0000, period_r};
      `BAFC_ADDR_STATE: prdata = {30'h0000_0000, gate_drive, fault_recovery};
      default: prdata = 32'h0000_0000;
    endcase
  end
  // fault events
  reg uv_busy_r;
  reg [31:0] uv_cnt_r;
  reg ovh_d_r, ovl_d_r;
  wire ev_ovl = ovl_q & ~ovl_d_r;
  wire ev_ovh = ovh_q & ~ovh_d_r;
  wire ev_ocp = uv_busy_r & uv_q & (uv_cnt_r == UV_LAST);
  wire [2:0] ev = {ev_ocp, ev_ovh, ev_ovl};
  wire rd_status = rd & (paddr == `BAFC_ADDR_STATUS);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 3'b000;
      mask_r <= 3'b111;
      period_r <= `BAFC_PERIOD_RESET;
      status_r <= 3'b000;
      en_d_r <= 1'b0;
      ovh_d_r <= 1'b0;
      ovl_d_r <= 1'b0;
    end else begin
      en_d_r <= en_q;
      ovh_d_r <= ovh_q;
      ovl_d_r <= ovl_q;
      if (wr && paddr == `BAFC_ADDR_CTRL) ctrl_r <= pwdata[2:0];
      else ctrl_r[`BAFC_CTRL_RESTART] <= 1'b0;
      if (wr && paddr == `BAFC_ADDR_MASK) mask_r <= pwdata[2:0];
      if (wr && paddr == `BAFC_ADDR_PERIOD) period_r <= pwdata[15:0];
      if ((en_d_r & ~en_q) | rd_status | (wr && paddr == `BAFC_ADDR_STATUS))
        status_r <= ev;
      else
        status_r <= status_r | ev;
    end
  end
  assign boost_overvolt_low_flag = status_r[`BAFC_ST_OVL];
  assign boost_overvolt_high_flag = status_r[`BAFC_ST_OVH];
  assign boost_overcurrent_flag = status_r[`BAFC_ST_OCP];
  assign int_out = 1'b0;
  assign int_oe = |(status_r & mask_r);
  // under-voltage timer and recovery state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_busy_r <= 1'b0;
      uv_cnt_r <= 32'h0000_0000;
      fault_recovery <= 1'b0;
    end else begin
      if (!en_q || !uv_q || fault_recovery) begin
        uv_busy_r <= 1'b0;
        uv_cnt_r <= 32'h0000_0000;
      end else if (!uv_busy_r) begin
        uv_busy_r <= 1'b1;
      end else if (uv_cnt_r != UV_LAST) begin
        uv_cnt_r <= uv_cnt_r + 32'h0000_0001;
      end
      if (!en_q || ctrl_r[`BAFC_CTRL_RESTART]) fault_recovery <= 1'b0;
      else if (ev_ovh | ev_ocp) fault_recovery <= 1'b1;
    end
  end
  // switching cycle with current limit and min times
  reg [15:0] cyc_r;
  reg [15:0] on_r;
  reg cl_hit_r;
  wire hf = ctrl_r[`BAFC_CTRL_HIGHFREQ];
  wire [15:0] min_on = hf ? MIN_ON_HF[15:0] : MIN_LF[15:0];
  wire [15:0] min_off = hf ? MIN_OFF_HF[15:0] : MIN_LF[15:0];
  wire [15:0] max_on = period_r - min_off;
  wire cyc_end = (cyc_r >= period_r - 16'h0001);
  wire run = en_q & ~fault_recovery & ~ovl_q;
  wire sinks_on = ctrl_r[`BAFC_CTRL_SINKS_ON];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_r <= 16'h0000;
      on_r <= 16'h0000;
      cl_hit_r <= 1'b0;
      gate_drive <= 1'b0;
    end else begin
      cyc_r <= cyc_end ? 16'h0000 : cyc_r + 16'h0001;
      if (cyc_end) begin
        cl_hit_r <= 1'b0;
        on_r <= 16'h0000;
        gate_drive <= run;
      end else begin
        if (gate_drive) on_r <= on_r + 16'h0001;
        if (gate_drive && cl_q && on_r + 16'h0001 >= min_on) begin
          cl_hit_r <= 1'b1;
          gate_drive <= 1'b0;
        end else if (!run || on_r + 16'h0001 >= max_on) begin
          gate_drive <= 1'b0;
        end
      end
    end
  end
  // adaptive target loop
  reg [31:0] ad_cnt_r;
  wire [NCH-1:0] mon = string_config_select & ~string_fault_in;
  wire low_any = |(mon & hd_q);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ad_cnt_r <= 32'h0000_0000;
      boost_target <= INIT_T;
    end else begin
      ad_cnt_r <= (ad_cnt_r == AD_LAST) ? 32'h0000_0000 : ad_cnt_r + 32'h0000_0001;
      if (!en_q || !sinks_on) begin
        boost_target <= INIT_T;
      end else if (ad_cnt_r == AD_LAST && !fault_recovery && mon != {NCH{1'b0}}) begin
        if (low_any && boost_target != TMAX)
          boost_target <= boost_target + {{(TW-1){1'b0}}, 1'b1};
        else if (!low_any && boost_target != {TW{1'b0}})
          boost_target <= boost_target - {{(TW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// >>> hw/bafc_regs.vh
// register offsets, fields and timing constants of the boost fault controller
`ifndef BAFC_REGS_VH
`define BAFC_REGS_VH
`define BAFC_ADDR_CTRL 8'h00
`define BAFC_ADDR_STATUS 8'h04
`define BAFC_ADDR_MASK 8'h08
`define BAFC_ADDR_TARGET 8'h0C
`define BAFC_ADDR_PERIOD 8'h10
`define BAFC_ADDR_STATE 8'h14
`define BAFC_CTRL_SINKS_ON 0
`define BAFC_CTRL_HIGHFREQ 1
`define BAFC_CTRL_RESTART 2
`define BAFC_ST_OVL 0
`define BAFC_ST_OVH 1
`define BAFC_ST_OCP 2
`define BAFC_PERIOD_RESET 16'h0190
`define BAFC_TARGET_MAX 10'h3FF
`define BAFC_INIT_PCT 88
`define BAFC_CLK_NS 10
`define BAFC_MIN_T_LF_NS 150
`define BAFC_MIN_OFF_HF_NS 40
`define BAFC_MIN_ON_HF_NS 110
`define BAFC_UV_TIME_MS 110
`define BAFC_ADAPT_CYC 1000
`endif

// >>> bench/bafc_power_stage.sv
// power stage model: sense ramp hits the limit after ramp_cycles of conduction
`timescale 1ns/1ps
module bafc_power_stage (
  input wire pclk,
  input wire gate_drive,
  input wire [7:0] ramp_cycles,
  output logic current_limit_in
);
  logic [7:0] on_cnt_r = 8'h00;
  initial current_limit_in = 1'b0;
  // current builds while the fet conducts and collapses once it is off
  always @(posedge pclk) begin
    on_cnt_r <= gate_drive ? on_cnt_r + 8'h01 : 8'h00;
    current_limit_in <= gate_drive && on_cnt_r >= ramp_cycles;
  end
endmodule

// >>> bench/bafc_ctrl_assertions.sv
// port checks of the boost fault controller
`timescale 1ns/1ps
module bafc_ctrl_assertions #(
  parameter TW = 10,
  parameter UV_CYCLES = 50
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire enable_in,
  input wire current_limit_in,
  input wire overvolt_low_level,
  input wire overvolt_high_level,
  input wire undervolt_level,
  input wire gate_drive,
  input wire [TW-1:0] boost_target,
  input wire fault_recovery,
  input wire int_out,
  input wire boost_overvolt_high_flag
);
  logic [7:0] uv_cnt_r;
  // consecutive cycles of under-voltage
  always @(posedge pclk or negedge presetn)
    if (!presetn) uv_cnt_r <= 8'h00;
    else uv_cnt_r <= !undervolt_level ? 8'h00 : uv_cnt_r + {7'h00, uv_cnt_r != 8'hFF};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_limit_cut: assert property ($rose(current_limit_in) |-> ##[0:20] !gate_drive)
    else $error("gate not cut by current limit");
  a_min_on: assert property ($rose(gate_drive) && !overvolt_low_level && !overvolt_high_level
    && !undervolt_level && enable_in |-> gate_drive[*4])
    else $error("on time too short");
  a_min_off: assert property ($fell(gate_drive) |-> !gate_drive[*4])
    else $error("off time too short");
  a_ovl_stop: assert property ($rose(overvolt_low_level) ##20 overvolt_low_level |-> !gate_drive)
    else $error("switching during low over-voltage");
  a_ovh_recovery: assert property ($rose(overvolt_high_level) && enable_in
    |-> ##[1:8] fault_recovery)
    else $error("no recovery on high over-voltage");
  a_uv_expiry: assert property (uv_cnt_r == UV_CYCLES + 8 |-> fault_recovery)
    else $error("no recovery after under-voltage time");
  a_int_drain: assert property (!int_out)
    else $error("interrupt pin driven high");
  a_flag_sticky: assert property ($fell(boost_overvolt_high_flag) && enable_in
    && $past(enable_in, 8) |-> $past(psel && penable && paddr == 8'h04))
    else $error("flag dropped without clear");
  a_recov_gate: assert property (fault_recovery ##1 fault_recovery |-> !gate_drive)
    else $error("gate on in recovery");
  a_target_frozen: assert property (fault_recovery ##1 fault_recovery |-> $stable(boost_target))
    else $error("target moved in recovery");
  c_limit: cover property (current_limit_in ##1 !gate_drive);
  c_recovery: cover property (fault_recovery[*4]);
  c_ovh: cover property ($rose(boost_overvolt_high_flag));
endmodule
bind bafc_ctrl bafc_ctrl_assertions #(.TW(TW), .UV_CYCLES(UV_CYCLES)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .enable_in(enable_in),
  .current_limit_in(current_limit_in), .overvolt_low_level(overvolt_low_level),
  .overvolt_high_level(overvolt_high_level), .undervolt_level(undervolt_level),
  .gate_drive(gate_drive), .boost_target(boost_target), .fault_recovery(fault_recovery),
  .int_out(int_out), .boost_overvolt_high_flag(boost_overvolt_high_flag));

// >>> bench/tb_boost_adaptive_fault_ctrl.sv
// self-checking bench of the boost fault controller
`timescale 1ns/1ps
module tb_boost_adaptive_fault_ctrl;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, enable_in = 1;
  logic ovl = 0, ovh = 0, uv = 0, lim;
  logic [7:0] paddr = 8'h00, ramp = 8'h01;
  logic [31:0] pwdata = 32'h0000_0000, rd;
  logic [5:0] cfg = 6'h0F, sfault = 6'h00, sink = 6'h00;
  wire [31:0] prdata;
  wire [9:0] tgt;
  wire pready, pslverr, gate, rec, int_out, int_oe, f_ovl, f_ovh, f_ocp;
  int err_total = 0, checks_done = 0, n, t;
  always #5 pclk = ~pclk;
  bafc_ctrl #(.UV_CYCLES(50), .ADAPT_CYCLES(8)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .enable_in(enable_in),
    .current_limit_in(lim), .overvolt_low_level(ovl), .overvolt_high_level(ovh),
    .undervolt_level(uv), .string_config_select(cfg), .string_fault_in(sfault),
    .led_sink_output(sink), .gate_drive(gate), .boost_target(tgt), .fault_recovery(rec),
    .int_out(int_out), .int_oe(int_oe), .boost_overvolt_low_flag(f_ovl),
    .boost_overvolt_high_flag(f_ovh), .boost_overcurrent_flag(f_ocp));
  bafc_power_stage u_stage (.pclk(pclk), .gate_drive(gate), .ramp_cycles(ramp),
    .current_limit_in(lim));
  task check(input [31:0] got, input [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task apb(input logic w, input [7:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 0; penable <= 0;
  endtask
  task gate_on;
    n = 0;
    for (int i = 0; i < 900 && gate !== 1'b1; i++) @(posedge pclk);
    while (gate === 1'b1 && n < 900) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task t_regs;
    cyc(20);
    check(tgt, 32'h0000_0384);
    apb(0, 8'h08, 0); check(rd, 32'h0000_0007);
    apb(0, 8'h10, 0); check(rd, 32'h0000_0190);
    apb(0, 8'h20, 0); check(rd, 0);
    check(pslverr, 0);
    check(int_out, 0);
    apb(0, 8'h0C, 0); check(rd, 32'h0000_0384);
  endtask
  task t_limit;
    apb(1, 8'h10, 32'h0000_0064);
    gate_on; check(n inside {[15:17]}, 1);
    ramp <= 8'hFF; gate_on; check(n inside {[84:86]}, 1);
    apb(1, 8'h00, 2); ramp <= 8'h01; gate_on; check(n inside {[11:13]}, 1);
    apb(0, 8'h04, 0); check({rd[2:0], int_oe, rec}, 0);
    apb(1, 8'h00, 0); ramp <= 8'h14;
  endtask
  task t_adapt;
    sink <= 6'h30; apb(1, 8'h00, 1); cyc(60); check(tgt < 900, 1);
    t = tgt; sink <= 6'h01; cyc(40); check(tgt > t, 1);
    t = tgt; sfault <= 6'h01; cyc(40); check(tgt < t, 1);
  endtask
  task t_ovl;
    ovl <= 1; cyc(25); check({gate, int_oe}, 1);
    check(f_ovl, 1);
    ovl <= 0; gate_on; check(n > 0, 1);
    apb(0, 8'h04, 0); check(rd, 1);
    apb(0, 8'h04, 0); check({rd, int_oe}, 0);
  endtask
  task t_ovh;
    apb(1, 8'h08, 0); ovh <= 1; cyc(12); check({rec, int_oe}, 2);
    ovh <= 0; t = tgt; cyc(200); check(tgt, t);
    apb(1, 8'h08, 2); cyc(1); check({int_oe, f_ovh}, 3);
    apb(1, 8'h04, 0); apb(1, 8'h08, 7);
    apb(1, 8'h00, 5); cyc(2); check({rec, f_ovh}, 0);
  endtask
  task t_uv;
    uv <= 1; cyc(30); uv <= 0; cyc(60); check({rec, f_ocp}, 0);
    uv <= 1; cyc(70); check({rec, f_ocp}, 3);
    uv <= 0; enable_in <= 0; cyc(12); check(f_ocp, 0);
  endtask
  task results;
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    results;
  end
  initial begin
    cyc(6);
    presetn <= 1;
    t_regs; t_limit; t_adapt; t_ovl; t_ovh; t_uv;
    results;
  end
endmodule
